// File: src/dhb_defs.svh
// Constants for the dual-mode host bus interface
`ifndef DHB_DEFS_SVH
`define DHB_DEFS_SVH
`define DHB_ROM_LO        20'hC0000
`define DHB_ROM_HI        20'hC7FFF
`define DHB_ROM_HOLE_LO   20'hC6000
`define DHB_ROM_HOLE_HI   20'hC67FF
`define DHB_PORT_ROMPAGE  16'h46E8
`define DHB_VGA_IO_LO     16'h03B0
`define DHB_VGA_IO_HI     16'h03DF
`define DHB_IRQ_EN_BIT    5
`define DHB_IRQ_CLR_BIT   4
`define DHB_ROM_EN_BIT    0
`define DHB_ROM_MAP_BIT   0
`define DHB_WAIT_CYCLES   4'h3
`define DHB_STROBE_CYCLES 4'h2
`endif

// File: src/dhb_pkg.sv
// Types for the dual-mode host bus interface
package dhb_pkg;
  typedef enum logic [1:0] {
    DHB_IDLE,
    DHB_WAIT,
    DHB_DONE
  } dhb_state_t;
endpackage : dhb_pkg

// File: src/dhb_sync.sv
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module dhb_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  // Data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta;
  // Reset value per bit, so a pin idling low wakes with no false edge
  for (genvar g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        meta[g] <= RST_VAL[g];
        o_q[g]  <= RST_VAL[g];
      end else begin
        meta[g] <= i_d[g];
        o_q[g]  <= meta[g];
      end
    end
  end
  initial begin
    if (W < 1) $error("dhb_sync width must be positive");
  end
endmodule : dhb_sync
`default_nettype wire

// File: src/dhb_host_if.sv
// Dual-mode host bus interface: decode, strobes, ready, ROM select, interrupt
`include "dhb_defs.svh"
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE_01: high address bits feed video memory address only, never I/O decode.
// RULE_02: SA0 and byte-high-enable both low give a 16-bit transfer, else byte.
// RULE_03: outside decode drives memory decode enable high to enable memory; in channel mode the code also needs I/O decode enable high.
// RULE_04: I/O decode enable is active low in AT, active high in channel mode.
// RULE_05: host drives ALE in AT mode, slot setup in channel mode.
// RULE_06: interrupt output only drives while enable bit 5 is set.
// RULE_07: interrupt is active high in AT mode, active low in channel mode.
// RULE_08: display end sets latched interrupt; writing clear bit 4 clears it.
// RULE_09: AT mode ROM select low for C0000-C7FFF when enable bit permits.
// RULE_10: ROM hole up to C67FF stays deselected unless map bit cleared.
// RULE_11: write to port 46E8 pulses ROM select as page register strobe.
// RULE_12: channel mode drives ROM select pin as card selected feedback.
// RULE_13: 16-bit acknowledge for video memory in AT, memory or I/O in channel.
// RULE_14: ready pulled low for wait states only on video memory cycles.
// RULE_15: buffer direction outputs low only during memory or I/O reads.
// RULE_16: variant may route CRT syncs onto the direction pins.
// RULE_17: memory read pin is read strobe in AT, memory/IO select in channel.
// RULE_18: memory write pin is write strobe in AT, status S0 in channel.
// RULE_19: channel CMD low marks address valid, rising edge ends the cycle.
// RULE_20: I/O read pin is read strobe in AT, status S1 in channel.
// RULE_21: bus mode is a strap caught at reset release; pins follow it.
module dhb_host_if #(
  parameter logic [3:0] WAIT_CYCLES = `DHB_WAIT_CYCLES
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // Mode strap, high selects channel mode
  input  wire logic        i_channel_mode,
  // Host address and control pins
  input  wire logic [2:0]  i_la,
  input  wire logic [16:0] i_sa,
  input  wire logic        i_sbhe_n,
  input  wire logic        i_memory_decode_enable,
  input  wire logic        i_io_decode_enable,
  input  wire logic        i_ale_setup,
  input  wire logic        i_memr_mio,
  input  wire logic        i_memw_s0,
  input  wire logic        i_ior_s1,
  input  wire logic        i_iow_cmd,
  // Register bits from the CRT and paging registers
  input  wire logic [7:0]  i_vsync_end_reg,
  input  wire logic        i_vsync_end_wr,
  input  wire logic [7:0]  i_rom_enable_config_reg,
  input  wire logic [7:0]  i_rom_window_map_reg,
  // Display events and sync routing
  input  wire logic        i_display_end,
  input  wire logic        i_sync_on_dir,
  input  wire logic        i_crt_hsync,
  input  wire logic        i_crt_vsync,
  // Internal side
  output logic [19:0] o_vmem_addr,
  output logic        o_mem_cycle,
  output logic        o_io_cycle,
  output logic        o_wide,
  output logic        o_hi_byte,
  output logic        o_vga_io_hit,
  // Host response pins
  output logic        o_irq,
  output logic        o_irq_oe,
  output logic        o_bios_rom_select,
  output logic        o_cs16,
  output logic        o_ready,
  output logic        o_upper_byte_buffer_dir,
  output logic        o_lower_byte_buffer_dir
);
  logic        chan;
  logic        strap_taken;
  logic [25:0] pins_s;
  logic [2:0]  la_s;
  logic [16:0] sa_s;
  logic        sbhe_n_s, mde_s, ioe_s, ale_s, mio_s, s0_s, s1_s, cmd_s, disp_s;
  logic        disp_d;
  logic        mem_rd, mem_wr, io_rd, io_wr;
  logic        mem_en, io_en, mem_act, io_act;
  logic [19:0] full_addr;
  logic        rom_hit, rom_sel;
  logic        irq_flag;
  logic        io_wr_d;
  logic [3:0]  strobe_cnt;
  logic [3:0]  wait_cnt;
  logic        next_ready;
  dhb_pkg::dhb_state_t state;

  initial begin
    if (WAIT_CYCLES == 4'h0) $error("WAIT_CYCLES must be at least one");
  end

  // Pins cross into the clock domain; all idle high but display end, which idles low
  dhb_sync #(.W(26), .RST_VAL(26'h3FDFFFF)) u_sync_ctl (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_d       ({i_sbhe_n, i_memory_decode_enable, i_io_decode_enable, i_ale_setup,
                 i_memr_mio, i_memw_s0, i_ior_s1, i_iow_cmd, i_display_end,
                 i_la, i_sa[13:0]}),
    .o_q       (pins_s)
  );
  logic [2:0] sa_hi_s;
  dhb_sync #(.W(3)) u_sync_sa (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_d       (i_sa[16:14]),
    .o_q       (sa_hi_s)
  );
  assign {sbhe_n_s, mde_s, ioe_s, ale_s, mio_s, s0_s, s1_s, cmd_s, disp_s} = pins_s[25:17];
  assign la_s = pins_s[16:14];
  assign sa_s = {sa_hi_s, pins_s[13:0]};

  // RULE_21 strap capture
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      chan        <= 1'b0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      chan        <= i_channel_mode;
      strap_taken <= 1'b1;
    end
  end

  // RULE_17 RULE_18 RULE_19 RULE_20 pin meaning per mode
  always_comb begin
    if (chan) begin
      mem_rd = !cmd_s && mio_s && s0_s && !s1_s;
      mem_wr = !cmd_s && mio_s && !s0_s && s1_s;
      io_rd  = !cmd_s && !mio_s && s0_s && !s1_s;
      io_wr  = !cmd_s && !mio_s && !s0_s && s1_s;
    end else begin
      mem_rd = !mio_s;
      mem_wr = !s0_s;
      io_rd  = !s1_s;
      io_wr  = !cmd_s;
    end
  end

  // RULE_03 RULE_04 decode enables
  assign mem_en  = chan ? (mde_s && ioe_s) : mde_s;
  assign io_en   = chan ? ioe_s : !ioe_s;
  assign mem_act = mem_en && (mem_rd || mem_wr);
  assign io_act  = io_en && (io_rd || io_wr);

  // RULE_01 high bits only in memory address
  assign full_addr    = {la_s, sa_s};
  assign o_vmem_addr  = full_addr;
  assign o_vga_io_hit = io_act && (sa_s[15:0] >= `DHB_VGA_IO_LO)
                        && (sa_s[15:0] <= `DHB_VGA_IO_HI);
  assign o_mem_cycle  = mem_act;
  assign o_io_cycle   = io_act;

  // RULE_02 transfer width and lane
  assign o_wide    = !sa_s[0] && !sbhe_n_s;
  assign o_hi_byte = sa_s[0] && !sbhe_n_s;

  // RULE_09 RULE_10 ROM window
  // Map bit can only narrow the window, never widen it
  assign rom_hit = (full_addr >= `DHB_ROM_LO) && (full_addr <= `DHB_ROM_HI)
                   && i_rom_enable_config_reg[`DHB_ROM_EN_BIT]
                   && !(full_addr >= `DHB_ROM_HOLE_LO && full_addr <= `DHB_ROM_HOLE_HI
                        && i_rom_window_map_reg[`DHB_ROM_MAP_BIT]);

  // RULE_11 page register strobe on write to 46E8
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      io_wr_d    <= 1'b0;
      strobe_cnt <= 4'h0;
    end else begin
      // Edge of the decoded write, so a long strobe gives one pulse only
      io_wr_d <= io_wr && io_en && (sa_s[15:0] == `DHB_PORT_ROMPAGE);
      if (io_wr && io_en && (sa_s[15:0] == `DHB_PORT_ROMPAGE) && !io_wr_d)
        strobe_cnt <= `DHB_STROBE_CYCLES;
      else if (strobe_cnt != 4'h0)
        strobe_cnt <= strobe_cnt - 4'h1;
    end
  end

  // RULE_12 card feedback in channel mode
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rom_sel <= 1'b1;
    end else if (chan) begin
      rom_sel <= !(mem_en && !cmd_s && (mem_rd || mem_wr || io_act));
    end else begin
      rom_sel <= !((rom_hit && mem_rd && mem_en) || strobe_cnt != 4'h0);
    end
  end
  assign o_bios_rom_select = rom_sel;

  // RULE_13 16-bit acknowledge
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cs16 <= 1'b1;
    end else if (chan) begin
      o_cs16 <= !((mem_act && !rom_hit) || io_act);
    end else begin
      o_cs16 <= !(mem_en && !rom_hit && (mem_rd || mem_wr));
    end
  end

  // RULE_14 wait states for video memory only
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state    <= dhb_pkg::DHB_IDLE;
      wait_cnt <= 4'h0;
    end else begin
      unique case (state)
        dhb_pkg::DHB_IDLE: begin
          if (mem_act && !rom_hit) begin
            state    <= dhb_pkg::DHB_WAIT;
            wait_cnt <= WAIT_CYCLES;
          end
        end
        dhb_pkg::DHB_WAIT: begin
          if (wait_cnt == 4'h1) state <= dhb_pkg::DHB_DONE;
          wait_cnt <= wait_cnt - 4'h1;
        end
        dhb_pkg::DHB_DONE: begin
          if (!mem_act) state <= dhb_pkg::DHB_IDLE;
        end
        default: state <= dhb_pkg::DHB_IDLE;
      endcase
    end
  end
  // Ready drops in the first decoded cycle; a registered ready would come late
  assign next_ready = !((state == dhb_pkg::DHB_IDLE && mem_act && !rom_hit)
                        || state == dhb_pkg::DHB_WAIT);
  assign o_ready = next_ready;

  // RULE_15 RULE_16 buffer direction or CRT syncs
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_upper_byte_buffer_dir <= 1'b1;
      o_lower_byte_buffer_dir <= 1'b1;
    end else if (i_sync_on_dir) begin
      o_upper_byte_buffer_dir <= i_crt_hsync;
      o_lower_byte_buffer_dir <= i_crt_vsync;
    end else begin
      o_upper_byte_buffer_dir <= !((mem_rd && mem_en) || (io_rd && io_en));
      o_lower_byte_buffer_dir <= !((mem_rd && mem_en) || (io_rd && io_en));
    end
  end

  // RULE_08 latched display-end interrupt, set wins over clear
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      disp_d   <= 1'b0;
      irq_flag <= 1'b0;
    end else begin
      disp_d <= disp_s;
      if (disp_s && !disp_d)
        irq_flag <= 1'b1;
      else if (i_vsync_end_wr && !i_vsync_end_reg[`DHB_IRQ_CLR_BIT])
        irq_flag <= 1'b0;
    end
  end

  // RULE_06 RULE_07 enable and polarity
  assign o_irq_oe = i_vsync_end_reg[`DHB_IRQ_EN_BIT];
  assign o_irq    = chan ? !irq_flag : irq_flag;

  irq_en_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_06
    !i_vsync_end_reg[`DHB_IRQ_EN_BIT] |-> !o_irq_oe)
    else $error("interrupt driven while disabled");
  irq_pol_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_07
    o_irq == (chan ^ irq_flag))
    else $error("interrupt polarity wrong");
  irq_set_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_08
    (disp_s && !disp_d) |=> irq_flag)
    else $error("display end did not latch interrupt");
  ready_io_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_14
    (state == dhb_pkg::DHB_IDLE && !mem_act) |-> o_ready)
    else $error("wait inserted outside memory cycle");
  ready_len_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_14
    $rose(state == dhb_pkg::DHB_WAIT) |-> ##3 state != dhb_pkg::DHB_WAIT)
    else $error("wait length wrong");
  dir_idle_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_15
    (!i_sync_on_dir && !mem_rd && !io_rd) |=> o_lower_byte_buffer_dir || i_sync_on_dir)
    else $error("direction low outside read");
  strap_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_21
    strap_taken |=> $stable(chan))
    else $error("mode changed after reset");
  wide_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_02
    o_wide |-> !o_hi_byte)
    else $error("wide and high byte together");

  // RULE_13 no ack on ROM
  cs16_rom_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_13
    (!chan && rom_hit) |=> o_cs16)
    else $error("16-bit acknowledge on ROM access");
  // RULE_13 ack on video read
  cs16_mem_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_13
    (!chan && mem_en && !rom_hit && mem_rd) |=> !o_cs16)
    else $error("16-bit acknowledge missing on video memory");
  // RULE_14 no wait on ROM
  ready_rom_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_14
    (state == dhb_pkg::DHB_IDLE && rom_hit) |-> o_ready)
    else $error("wait inserted on ROM access");
  // RULE_14 wait on video memory
  ready_wait_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_14
    (state == dhb_pkg::DHB_IDLE && mem_act && !rom_hit) |-> !o_ready)
    else $error("no wait on video memory cycle");
  // RULE_15 direction low in reads
  dir_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_15
    (!i_sync_on_dir && ((mem_rd && mem_en) || (io_rd && io_en)))
    |=> (!o_upper_byte_buffer_dir && !o_lower_byte_buffer_dir))
    else $error("direction not low during read");
  // RULE_16 syncs on direction pins
  dir_sync_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_16
    i_sync_on_dir |=> ((o_upper_byte_buffer_dir == $past(i_crt_hsync))
                       && (o_lower_byte_buffer_dir == $past(i_crt_vsync))))
    else $error("syncs not routed to direction pins");
  // RULE_11 strobe length
  strobe_len_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_11
    $rose(strobe_cnt != 4'h0) |-> ##2 (strobe_cnt == 4'h0))
    else $error("page strobe length wrong");
  // RULE_11 strobe on pin
  strobe_pin_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_11
    (!chan && strobe_cnt != 4'h0) |=> !o_bios_rom_select)
    else $error("page strobe missing on ROM select");
  // RULE_09 ROM enable bit
  rom_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_09
    !i_rom_enable_config_reg[`DHB_ROM_EN_BIT] |-> !rom_hit)
    else $error("ROM hit while ROM disabled");
  // RULE_10 hole kept out
  rom_hole_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_10
    (i_rom_window_map_reg[`DHB_ROM_MAP_BIT] && (full_addr >= `DHB_ROM_HOLE_LO)
     && (full_addr <= `DHB_ROM_HOLE_HI)) |-> !rom_hit)
    else $error("ROM hit inside unmapped hole");
  // RULE_12 card feedback given
  chan_fb_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_12
    (chan && mem_act) |=> !o_bios_rom_select)
    else $error("no card feedback in channel mode");
  // RULE_08 clear by write
  irq_clr_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_08
    (i_vsync_end_wr && !i_vsync_end_reg[`DHB_IRQ_CLR_BIT] && !(disp_s && !disp_d))
    |=> !irq_flag)
    else $error("interrupt not cleared by write");
  // RULE_08 flag stays latched
  irq_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_08
    (irq_flag && !i_vsync_end_wr) |=> irq_flag)
    else $error("interrupt dropped without clear");
  cv_irq: cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(irq_flag));
  cv_setup: cover property (@(posedge i_clk) disable iff (!i_nrst) chan && !ale_s);
  cv_feedback: cover property (@(posedge i_clk) disable iff (!i_nrst) chan && !o_bios_rom_select);
  cv_wait: cover property (@(posedge i_clk) disable iff (!i_nrst) $fell(o_ready));
  cv_strobe: cover property (@(posedge i_clk) disable iff (!i_nrst) strobe_cnt != 4'h0);
endmodule : dhb_host_if
`default_nettype wire

// File: verif/dhb_host_model.sv
// Host side model driving the bus pins in either bus mode
`timescale 1ns/1ps
`default_nettype none
module dhb_host_model (
  // Mode strap seen by the host
  input  wire logic        i_chan,
  // Pins toward the device
  output var  logic [2:0]  o_la,
  output var  logic [16:0] o_sa,
  output var  logic        o_sbhe_n,
  output var  logic        o_mem_en,
  output var  logic        o_io_en,
  output var  logic        o_ale,
  output var  logic        o_memr,
  output var  logic        o_memw,
  output var  logic        o_ior,
  output var  logic        o_iow
);
  initial begin
    {o_la, o_sa} = 20'h5A5A5;
    o_sbhe_n = 1'b0;
    idle();
  end
  // Released lines flip so a stale address never looks valid
  task automatic idle();
    {o_la, o_sa} = ~{o_la, o_sa};
    o_sbhe_n = ~o_sbhe_n;
    o_mem_en = 1'b0;
    o_ale = 1'b0;
    o_io_en = 1'b1;
    {o_memr, o_memw, o_ior, o_iow} = 4'hF;
  endtask : idle
  // Kind: 0 mem read, 1 mem write, 2 I/O read, 3 I/O write
  task automatic start(input logic [1:0] k, input logic [19:0] a, input logic hb_n);
    {o_la, o_sa} = a;
    o_sbhe_n = hb_n;
    o_mem_en = ~k[1];
    o_ale = ~i_chan;
    o_io_en = i_chan | ~k[1];
    if (i_chan) {o_memr, o_memw, o_ior, o_iow} = {~k[1], ~k[0], k[0], 1'b0};
    else {o_memr, o_memw, o_ior, o_iow} = ~(4'h8 >> k);
  endtask : start
endmodule : dhb_host_model
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the dual-mode host bus interface
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, nrst = 1'b0, chan = 1'b0, vwr = 1'b0, de = 1'b0;
  logic son = 1'b0, hs = 1'b0, vs = 1'b0;
  logic [7:0] vreg = 8'h00, ren = 8'h01, rmap = 8'h01;
  logic [2:0] la;
  logic [16:0] sa;
  logic sbhe_n, men, ien, ale, memr, memw, ior, iow;
  logic [19:0] vma;
  logic mcy, icy, wide, hib, hit, irq, ioe, rsel, cs16, rdy, ubd, lbd;
  logic [3:0] sel_q[$];
  logic [19:0] exp_q[$], a;
  // Address, enable, map bit, expected select
  logic [23:0] rom_t [7] = '{24'hC0000C, 24'hC7FFFC, 24'hC6000E, 24'hC67FF8,
                             24'hC6800C, 24'hC8000E, 24'hC00006};
  int bad_count = 0, checks_done = 0, cycles = 0, lowcnt = 0;
  event noted;
  always #2 clk = ~clk;
  dhb_host_model model (.i_chan(chan), .o_la(la), .o_sa(sa), .o_sbhe_n(sbhe_n),
    .o_mem_en(men), .o_io_en(ien), .o_ale(ale), .o_memr(memr), .o_memw(memw),
    .o_ior(ior), .o_iow(iow));
  dhb_host_if u_dut (.i_clk(clk), .i_nrst(nrst), .i_channel_mode(chan), .i_la(la),
    .i_sa(sa), .i_sbhe_n(sbhe_n), .i_memory_decode_enable(men),
    .i_io_decode_enable(ien), .i_ale_setup(ale), .i_memr_mio(memr),
    .i_memw_s0(memw), .i_ior_s1(ior), .i_iow_cmd(iow), .i_vsync_end_reg(vreg),
    .i_vsync_end_wr(vwr), .i_rom_enable_config_reg(ren),
    .i_rom_window_map_reg(rmap), .i_display_end(de), .i_sync_on_dir(son),
    .i_crt_hsync(hs), .i_crt_vsync(vs), .o_vmem_addr(vma), .o_mem_cycle(mcy),
    .o_io_cycle(icy), .o_wide(wide), .o_hi_byte(hib), .o_vga_io_hit(hit),
    .o_irq(irq), .o_irq_oe(ioe), .o_bios_rom_select(rsel), .o_cs16(cs16),
    .o_ready(rdy), .o_upper_byte_buffer_dir(ubd), .o_lower_byte_buffer_dir(lbd));
  function automatic logic [19:0] pick(input logic [3:0] s);
    case (s)
      4'h0: return {19'h0, rsel};
      4'h1: return {19'h0, cs16};
      4'h2: return {19'h0, rdy};
      4'h3: return {18'h0, ubd, lbd};
      4'h4: return {19'h0, irq};
      4'h5: return {19'h0, ioe};
      4'h6: return {19'h0, hit};
      4'h7: return {18'h0, wide, hib};
      4'h8: return vma;
      4'h9: return {19'h0, mcy};
      4'hA: return {19'h0, icy};
      default: return 20'(lowcnt);
    endcase
  endfunction : pick
  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic note(input logic [3:0] s, input logic [19:0] e);
    sel_q.push_back(s);
    exp_q.push_back(e);
    -> noted;
  endtask : note
  // Watcher runs once the driver blocks, so outputs are settled
  initial forever begin
    @(noted);
    while (sel_q.size() > 0) begin
      check(pick(sel_q[0]), exp_q[0]);
      void'(sel_q.pop_front());
      void'(exp_q.pop_front());
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic do_reset(input logic c);
    nrst = 1'b0;
    chan = c;
    step(5);
    nrst = 1'b1;
    step(3);
  endtask : do_reset
  task automatic fin();
    model.idle();
    step(5);
  endtask : fin
  task automatic pulse_de();
    de = 1'b0;
    step(2);
    de = 1'b1;
    step(5);
  endtask : pulse_de
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(51));
    do_reset(1'b0);
    for (int i = 0; i < 4; i++) begin
      a = {4'hA, 15'($urandom()), i[0]};
      model.start(2'd0, a, i[1]);
      step(3);
      note(4'h2, 20'h0);
      step(4);
      note(4'h2, 20'h1);
      note(4'h8, a);
      note(4'h7, {18'h0, i == 0, i == 1});
      note(4'h3, 20'h0);
      note(4'h9, 20'h1);
      if (i == 0) note(4'h1, 20'h0);
      fin();
    end
    model.start(2'd1, 20'hA0010, 1'b0);
    step(7);
    note(4'h3, 20'h3);
    note(4'h9, 20'h1);
    fin();
    $display("test lanes and write done");
    foreach (rom_t[j]) begin
      ren = {7'($urandom()), rom_t[j][3]};
      rmap = {7'($urandom()), rom_t[j][2]};
      model.start(2'd0, rom_t[j][23:4], 1'b1);
      step(3);
      note(4'h2, {19'h0, ~rom_t[j][1]});
      step(4);
      note(4'h0, {19'h0, rom_t[j][1]});
      fin();
    end
    ren = 8'h01;
    rmap = 8'h01;
    $display("test rom done");
    model.start(2'd2, {3'($urandom()), 17'h003C4}, 1'b1);
    step(3);
    note(4'h2, 20'h1);
    step(4);
    note(4'h6, 20'h1);
    note(4'hA, 20'h1);
    note(4'h3, 20'h0);
    model.o_io_en = 1'b1;
    step(6);
    note(4'h3, 20'h3);
    fin();
    model.start(2'd3, {3'($urandom()), 17'h046E8}, 1'b1);
    repeat (10) begin
      step(1);
      lowcnt += (rsel === 1'b0);
    end
    note(4'hB, 20'h2);
    fin();
    son = 1'b1;
    {hs, vs} = 2'($urandom());
    step(4);
    note(4'h3, {18'h0, hs, vs});
    son = 1'b0;
    $display("test io done");
    vreg = 8'h30;
    pulse_de();
    note(4'h4, 20'h1);
    note(4'h5, 20'h1);
    vreg = 8'h20;
    vwr = 1'b1;
    step(1);
    vwr = 1'b0;
    step(3);
    note(4'h4, 20'h0);
    vreg = 8'h10;
    step(2);
    note(4'h5, 20'h0);
    $display("test irq done");
    do_reset(1'b1);
    vreg = 8'h30;
    pulse_de();
    note(4'h4, 20'h0);
    chan = 1'b0;
    step(4);
    note(4'h4, 20'h0);
    chan = 1'b1;
    model.start(2'd0, 20'hA0000, 1'b0);
    step(7);
    note(4'h9, 20'h1);
    note(4'h3, 20'h0);
    note(4'h1, 20'h0);
    note(4'h0, 20'h0);
    fin();
    note(4'h9, 20'h0);
    model.start(2'd2, 20'h003C4, 1'b1);
    step(7);
    note(4'hA, 20'h1);
    fin();
    $display("test channel done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
